// >>> pll_pd_pkg.sv
// Purpose: shared constants and carrier types for the power-down and lock block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz system clock
// Notes: phase error arrives from the phase detector already measured in ns
package pll_pd_pkg;

	// clock and lock timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MAIN_ENTRY_NS = 10;
	localparam int MAIN_EXIT_NS = 20;
	localparam int AUX_ENTRY_NS = 15;
	localparam int AUX_EXIT_NS = 30;
	localparam int LOCK_COUNT = 5;
	localparam int ERR_W = 8;
	localparam int CNT_W = 3;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAIN_DIV = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;

	// control register fields
	localparam int CTL_MAIN_PD = 0;
	localparam int CTL_AUX_PD = 1;
	localparam int CTL_MAIN_HIGHZ = 2;
	localparam int CTL_AUX_HIGHZ = 3;
	localparam int CTL_ATPU_LO = 4;
	localparam int CTL_TSEL_LO = 8;
	localparam int CTL_W = 12;
	localparam logic [CTL_W-1:0] CTL_RESET = 12'h003;

	// status register fields
	localparam int ST_MAIN_UP = 0;
	localparam int ST_AUX_UP = 1;
	localparam int ST_MAIN_LOCK = 2;
	localparam int ST_AUX_LOCK = 3;
	localparam int ST_AUTO = 4;
	localparam int ST_EN = 5;

	// interrupt events
	localparam int IRQ_W = 4;
	localparam int EV_MAIN_GAIN = 0;
	localparam int EV_MAIN_LOSS = 1;
	localparam int EV_AUX_GAIN = 2;
	localparam int EV_AUX_LOSS = 3;

	// test output selector codes
	localparam logic [3:0] TSEL_LOW = 4'h0;
	localparam logic [3:0] TSEL_MAIN = 4'h1;
	localparam logic [3:0] TSEL_AUX = 4'h2;
	localparam logic [3:0] TSEL_BOTH = 4'h3;

	localparam int DIV_W = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic strobe;
		logic [ERR_W-1:0] err_ns;
	} phase_sample_type;

	typedef struct packed {
		logic write;
		logic [7:0] addr;
	} ahb_phase_type;

	typedef enum logic [1:0] {
		SEC_ACTIVE,
		SEC_WAIT_PUMP,
		SEC_DOWN
	} sec_state_type;

endpackage

// >>> lock_window_det.sv
// Purpose: window lock detector with hysteresis for one loop
// Assumes: one strobe per comparison cycle, error in ns
// Notes: lock cleared and count flushed while the loop is powered down
module lock_window_det import pll_pd_pkg::*; #(
	parameter int ENTRY_NS = MAIN_ENTRY_NS,
	parameter int EXIT_NS = MAIN_EXIT_NS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// comparison samples
	input phase_sample_type sample,
	input wire logic powered_down,
	// result
	output logic lock_q
);
	localparam logic [ERR_W-1:0] ENTRY_LIM = ERR_W'(ENTRY_NS);
	localparam logic [ERR_W-1:0] EXIT_LIM = ERR_W'(EXIT_NS);
	localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(LOCK_COUNT - 1);

	logic [CNT_W-1:0] cnt_q;
	wire logic in_narrow = sample.err_ns < ENTRY_LIM;
	wire logic out_wide = sample.err_ns > EXIT_LIM;

	always_ff @(posedge clk_sys) begin
		if (srst || powered_down) begin
			cnt_q <= '0;
			lock_q <= 1'b0;
		end else if (sample.strobe && !lock_q) begin
			if (!in_narrow) begin
				cnt_q <= '0;
			end else if (cnt_q == LAST_CNT) begin
				cnt_q <= '0;
				lock_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end else if (sample.strobe && out_wide) begin
			lock_q <= 1'b0;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	pd_lock_low_a: assert property (powered_down |=> !lock_q)
		else $error("lock seen during power-down");
	lock_entry_a: assert property ($rose(lock_q) |->
		$past(cnt_q) == LAST_CNT && $past(sample.err_ns) < ENTRY_LIM)
		else $error("lock without five in-window cycles");
	cnt_clear_a: assert property (sample.strobe && !lock_q
		&& !in_narrow |=> cnt_q == '0 && !lock_q)
		else $error("count kept after out-of-window cycle");
	lock_drop_a: assert property (lock_q && sample.strobe
		&& out_wide |=> !lock_q)
		else $error("lock kept beyond wide window");
	lock_hold_a: assert property (lock_q && !powered_down
		&& !out_wide |=> lock_q)
		else $error("lock lost inside wide window");
endmodule

// >>> pd_section_ctrl.sv
// Purpose: power state of one synthesizer section
// Assumes: enable and pump-busy already synchronised
// Notes: outputs follow the next state, so they change one edge after inputs
module pd_section_ctrl import pll_pd_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// control
	input wire logic enable,
	input wire logic pd_bit,
	input wire logic highz_bit,
	input wire logic auto_up,
	input wire logic pump_busy,
	// section state
	output logic powered_q,
	output logic pump_en_q,
	output logic pump_highz_q
);
	sec_state_type state_q, state_d;

	// auto power-up beats the bits, the enable pin beats everything
	wire logic down_req = !enable || (!auto_up && pd_bit);
	wire logic async_pd = !enable || highz_bit;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SEC_ACTIVE: begin
				if (down_req) begin
					state_d = async_pd ? SEC_DOWN : SEC_WAIT_PUMP;
				end
			end
			SEC_WAIT_PUMP: begin
				if (!down_req) begin
					state_d = SEC_ACTIVE;
				end else if (async_pd || !pump_busy) begin
					state_d = SEC_DOWN;
				end
			end
			SEC_DOWN: begin
				if (!down_req) begin
					state_d = SEC_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= SEC_DOWN;
			powered_q <= 1'b0;
			pump_en_q <= 1'b0;
			pump_highz_q <= 1'b0;
		end else begin
			state_q <= state_d;
			powered_q <= state_d != SEC_DOWN;
			pump_en_q <= state_d == SEC_ACTIVE;
			pump_highz_q <= state_d == SEC_ACTIVE && highz_bit && !auto_up;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	en_low_down_a: assert property (!enable |=> !powered_q && !pump_en_q)
		else $error("section up with enable low");
	power_up_a: assert property (enable && !pd_bit && !highz_bit
		|=> powered_q && pump_en_q && !pump_highz_q)
		else $error("section not up with bits clear");
	auto_up_a: assert property (enable && auto_up
		|=> powered_q && pump_en_q && !pump_highz_q)
		else $error("auto power-up ignored");
	highz_active_a: assert property (enable && !auto_up
		&& !pd_bit && highz_bit |=> powered_q && pump_highz_q)
		else $error("pump not high impedance");
	async_down_a: assert property (enable && !auto_up
		&& pd_bit && highz_bit |=> !powered_q)
		else $error("asynchronous power-down late");
	sync_wait_a: assert property (powered_q && pump_busy && enable
		&& !auto_up && pd_bit && !highz_bit |=> powered_q && !pump_en_q)
		else $error("power removed while pump busy");
endmodule

// >>> pll_pd_top.sv
// Purpose: power-down control and lock detection behind an AHB-Lite slave
// Assumes: single word transfers, phase detector on clk_sys
// Notes: zero wait-state slave, every response OKAY
module pll_pd_top import pll_pd_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pins
	input wire logic en_pin,
	input wire logic main_pump_busy,
	input wire logic aux_pump_busy,
	// phase detector samples
	input phase_sample_type main_sample,
	input phase_sample_type aux_sample,
	// section control
	output logic main_powered,
	output logic main_pump_en,
	output logic main_pump_highz,
	output logic aux_powered,
	output logic aux_pump_en,
	output logic aux_pump_highz,
	output logic [DIV_W-1:0] main_divider,
	// indications
	output logic test_out,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] en_sync_q, mbusy_sync_q, abusy_sync_q;
	wire logic en_s = en_sync_q[1];
	wire logic mbusy_s = mbusy_sync_q[1];
	wire logic abusy_s = abusy_sync_q[1];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			en_sync_q <= '0;
			mbusy_sync_q <= '0;
			abusy_sync_q <= '0;
		end else begin
			en_sync_q <= {en_sync_q[0], en_pin};
			mbusy_sync_q <= {mbusy_sync_q[0], main_pump_busy};
			abusy_sync_q <= {abusy_sync_q[0], aux_pump_busy};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus address and data phase

	ahb_phase_type phase_q;
	logic wr_pend_q;
	logic [CTL_W-1:0] ctrl_q;
	logic auto_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
	logic main_lock, aux_lock;

	wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
	wire logic [7:0] raddr = haddr[7:0];
	wire logic wr_act = wr_pend_q && phase_q.write;
	wire logic wr_ctrl = wr_act && phase_q.addr == OFS_CTRL;
	wire logic wr_div = wr_act && phase_q.addr == OFS_MAIN_DIV;
	wire logic wr_clr = wr_act && phase_q.addr == OFS_IRQ_CLR;
	wire logic wr_en = wr_act && phase_q.addr == OFS_IRQ_EN;

	wire logic main_pd_bit = ctrl_q[CTL_MAIN_PD];
	wire logic aux_pd_bit = ctrl_q[CTL_AUX_PD];
	wire logic [1:0] atpu_sel = ctrl_q[CTL_ATPU_LO +: 2];
	wire logic [3:0] tsel = ctrl_q[CTL_TSEL_LO +: 4];

	wire logic [31:0] status_word = 32'({en_s, auto_q, aux_lock,
		main_lock, aux_powered, main_powered});

	// unmapped and write-only offsets read as zero
	wire logic [31:0] rd_word =
		raddr == OFS_CTRL ? 32'(ctrl_q) :
		raddr == OFS_MAIN_DIV ? 32'(main_divider) :
		raddr == OFS_STATUS ? status_word :
		raddr == OFS_IRQ_STAT ? 32'(irq_stat_q) :
		raddr == OFS_IRQ_EN ? 32'(irq_en_q) : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phase_q <= '0;
			wr_pend_q <= 1'b0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= take;
			if (take) begin
				phase_q <= '{write: hwrite, addr: raddr};
			end
			if (take && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	// auto power-up only latches while the part is enabled
	wire logic auto_set = wr_div && atpu_sel != 2'h0 && en_s;
	wire logic auto_clr = !en_s || wr_ctrl;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_q <= CTL_RESET;
			main_divider <= '0;
			irq_en_q <= '0;
			auto_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= hwdata[CTL_W-1:0];
			end
			if (wr_div) begin
				main_divider <= hwdata[DIV_W-1:0];
			end
			if (wr_en) begin
				irq_en_q <= hwdata[IRQ_W-1:0];
			end
			if (!en_s) begin
				auto_q <= 1'b0;
			end else if (auto_set) begin
				auto_q <= 1'b1;
			end else if (auto_clr) begin
				auto_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sections and lock detectors

	pd_section_ctrl u_main_sec (
		.clk_sys(clk_sys),
		.srst(srst),
		.enable(en_s),
		.pd_bit(main_pd_bit),
		.highz_bit(ctrl_q[CTL_MAIN_HIGHZ]),
		.auto_up(auto_q),
		.pump_busy(mbusy_s),
		.powered_q(main_powered),
		.pump_en_q(main_pump_en),
		.pump_highz_q(main_pump_highz)
	);

	// auto power-up is tied to the main divider only
	pd_section_ctrl u_aux_sec (
		.clk_sys(clk_sys),
		.srst(srst),
		.enable(en_s),
		.pd_bit(aux_pd_bit),
		.highz_bit(ctrl_q[CTL_AUX_HIGHZ]),
		.auto_up(1'b0),
		.pump_busy(abusy_s),
		.powered_q(aux_powered),
		.pump_en_q(aux_pump_en),
		.pump_highz_q(aux_pump_highz)
	);

	lock_window_det #(
		.ENTRY_NS(MAIN_ENTRY_NS),
		.EXIT_NS(MAIN_EXIT_NS)
	) u_main_lock (
		.clk_sys(clk_sys),
		.srst(srst),
		.sample(main_sample),
		.powered_down(!main_powered),
		.lock_q(main_lock)
	);

	lock_window_det #(
		.ENTRY_NS(AUX_ENTRY_NS),
		.EXIT_NS(AUX_EXIT_NS)
	) u_aux_lock (
		.clk_sys(clk_sys),
		.srst(srst),
		.sample(aux_sample),
		.powered_down(!aux_powered),
		.lock_q(aux_lock)
	);

	////////////////////////////////////////////////////////////////////////
	// test output and interrupts

	logic main_lock_q, aux_lock_q;
	wire logic both_lock = main_lock && aux_lock;
	wire logic test_d =
		tsel == TSEL_MAIN ? main_lock :
		tsel == TSEL_AUX ? aux_lock :
		tsel == TSEL_BOTH ? both_lock : 1'b0;

	wire logic [IRQ_W-1:0] events = {
		aux_lock_q && !aux_lock,
		!aux_lock_q && aux_lock,
		main_lock_q && !main_lock,
		!main_lock_q && main_lock
	};
	wire logic [IRQ_W-1:0] clr_mask = wr_clr ? hwdata[IRQ_W-1:0] : '0;
	// a new event in the clear cycle survives the clear
	wire logic [IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr_mask) | events;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			main_lock_q <= 1'b0;
			aux_lock_q <= 1'b0;
			irq_stat_q <= '0;
			test_out <= 1'b0;
			irq <= 1'b0;
		end else begin
			main_lock_q <= main_lock;
			aux_lock_q <= aux_lock;
			irq_stat_q <= irq_stat_d;
			test_out <= test_d;
			irq <= |(irq_stat_d & irq_en_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	combined_low_a: assert property (tsel == TSEL_BOTH
		&& !(main_lock && aux_lock) |=> !test_out)
		else $error("combined lock high with a loop unlocked");

	combined_high_a: assert property (tsel == TSEL_BOTH
		&& main_lock && aux_lock |=> test_out)
		else $error("combined lock low with both loops locked");

	main_view_a: assert property (tsel == TSEL_MAIN
		|=> test_out == $past(main_lock))
		else $error("test output does not follow main lock");

	main_pd_lock_a: assert property (!main_powered |=> !main_lock)
		else $error("main lock while powered down");

	aux_pd_lock_a: assert property (!aux_powered |=> !aux_lock)
		else $error("aux lock while powered down");

	en_low_off_a: assert property (!en_s |=> !auto_q
		&& !main_pump_en && !aux_pump_en)
		else $error("pump or auto power-up kept with enable low");

	auto_latch_a: assert property (auto_set |=> auto_q ##1
		main_powered && main_pump_en)
		else $error("divider write did not power up main loop");

	sec_isolate_a: assert property (en_s && !aux_pd_bit
		&& aux_powered && main_pd_bit ##1 en_s && !aux_pd_bit
		|-> aux_powered)
		else $error("aux section followed main power-down");

	sync_hold_a: assert property (en_s && !auto_q && main_pd_bit
		&& !ctrl_q[CTL_MAIN_HIGHZ] && mbusy_s && main_powered
		|=> main_powered)
		else $error("main power removed while pump busy");

	loss_sticky_a: assert property (main_lock_q && !main_lock
		|=> irq_stat_q[EV_MAIN_LOSS])
		else $error("main lock loss not recorded");

	gain_sticky_a: assert property (!main_lock_q && main_lock
		|=> irq_stat_q[EV_MAIN_GAIN])
		else $error("main lock gain not recorded");

	irq_sticky_a: assert property (|(irq_stat_q & irq_en_q) |=> irq
		|| $past(wr_clr))
		else $error("enabled status without interrupt");
endmodule

// >>> loop_model.sv
// Purpose: far-side loop model, phase samples and charge pump drain
// Assumes: comparison cycle is one in five clk_sys edges
// Notes: stuck keeps the pump on, as with no oscillator signal
module loop_model import pll_pd_pkg::*; #(
	parameter int OFF_CYC = 3
) (
	// clock
	input wire logic clk_sys,
	// stimulus
	input wire logic [ERR_W-1:0] err_set,
	input wire logic stuck,
	input wire logic pump_en,
	// loop outputs
	output phase_sample_type sample,
	output logic pump_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_q = 3'h0;
	int off_q = 0;
	////////////////////////////////////////////////////////////////////
	// 20 MHz comparison: lock trustworthy and under the maximum
	always_ff @(posedge clk_sys) begin
		div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
	end
	assign sample = '{strobe: div_q == 3'h4, err_ns: err_set};
	// pump drains a few cycles after it is told to stop
	// one steady pump current only: no fastlock setting can undercut it
	always_ff @(posedge clk_sys) begin
		if (pump_en) begin
			off_q <= OFF_CYC;
		end else if (off_q > 0) begin
			off_q <= off_q - 1;
		end
	end
	assign pump_busy = stuck || pump_en || off_q > 0;
endmodule

// >>> tb.sv
// Purpose: self-checking bench for power-down and lock block
// Assumes: zero wait-state slave, loop model on both loops
// Notes: expectations are hand-coded literal values plus some package constants
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("unexpected at %0t: got %0h exp %0h", \
	$time, g, e); end end
module tb import pll_pd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic en_pin = 1'b1;
	logic [ERR_W-1:0] main_err = 8'hFF;
	logic [ERR_W-1:0] aux_err = 8'hFF;
	logic main_stuck = 1'b0;
	logic hreadyout, hresp, main_pump_busy, aux_pump_busy;
	logic [31:0] hrdata;
	logic [31:0] rd;
	phase_sample_type main_sample, aux_sample;
	logic main_powered, main_pump_en, main_pump_highz;
	logic aux_powered, aux_pump_en, aux_pump_highz;
	logic [DIV_W-1:0] main_divider;
	logic test_out, irq;
	int mismatches = 0;
	int check_count = 0;
	////////////////////////////////////////////////////////////////////
	pll_pd_top pll_pd_top_i (.clk_sys, .srst, .hsel(1'b1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .en_pin, .main_pump_busy,
		.aux_pump_busy, .main_sample, .aux_sample, .main_powered,
		.main_pump_en, .main_pump_highz, .aux_powered, .aux_pump_en,
		.aux_pump_highz, .main_divider, .test_out, .irq);
	loop_model loop_model_i (.clk_sys, .err_set(main_err),
		.stuck(main_stuck), .pump_en(main_pump_en),
		.sample(main_sample), .pump_busy(main_pump_busy));
	loop_model loop_model_aux_i (.clk_sys, .err_set(aux_err),
		.stuck(1'b0), .pump_en(aux_pump_en),
		.sample(aux_sample), .pump_busy(aux_pump_busy));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	// request held until hready is sampled, data phase likewise
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		`CHK(rd, e)
		`CHK(hresp, 1'b0)
	endtask
	// returns right after the n-th strobe edge, before the next one
	task automatic strobes(input logic aux, input logic [7:0] e,
		input int n);
		int k;
		int t;
		if (aux)
			aux_err <= e;
		else
			main_err <= e;
		k = 0;
		t = 0;
		while (k < n && t < 200) begin
			@(posedge clk_sys);
			t++;
			if ((aux ? aux_sample.strobe : main_sample.strobe) === 1'b1)
				k++;
		end
		if (k < n) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset_regs;
		chk_rd(OFS_CTRL, {20'h0, CTL_RESET});
		chk_rd(OFS_STATUS, 32'h1 << ST_EN);
		chk_rd(8'h40, 32'h0);
		chk_rd(OFS_IRQ_CLR, 32'h0);
	endtask
	task automatic t_power_up;
		ahb(1'b1, OFS_CTRL, 32'h0);
		cycles(3);
		`CHK({main_powered, aux_powered, main_pump_en, main_pump_highz}, 4'hE)
		chk_rd(OFS_STATUS, 32'h23);
	endtask
	task automatic t_main_lock;
		strobes(1'b0, 8'h09, 4);
		strobes(1'b0, 8'h0A, 1);
		strobes(1'b0, 8'h09, 4);
		chk_rd(OFS_STATUS, 32'h23);
		strobes(1'b0, 8'h09, 1);
		chk_rd(OFS_STATUS, 32'h27);
		strobes(1'b0, 8'h14, 3);
		chk_rd(OFS_STATUS, 32'h27);
		strobes(1'b0, 8'h15, 1);
		chk_rd(OFS_STATUS, 32'h23);
	endtask
	task automatic t_aux_both;
		ahb(1'b1, OFS_CTRL, 32'h300);
		strobes(1'b1, 8'h0E, 5);
		strobes(1'b0, 8'h09, 5);
		cycles(2);
		`CHK(test_out, 1'b1)
		strobes(1'b1, 8'h1E, 1);
		cycles(2);
		`CHK(test_out, 1'b1)
		strobes(1'b1, 8'h1F, 1);
		cycles(2);
		`CHK(test_out, 1'b0)
		for (int s = 0; s < 5; s++) begin
			ahb(1'b1, OFS_CTRL, 32'(s) << CTL_TSEL_LO);
			cycles(3);
			`CHK(test_out, 1'(s == 1))
		end
	endtask
	task automatic t_irq;
		ahb(1'b1, OFS_IRQ_CLR, 32'hF);
		ahb(1'b1, OFS_IRQ_EN, 32'h1 << EV_MAIN_LOSS);
		strobes(1'b0, 8'h15, 1);
		cycles(2);
		`CHK(irq, 1'b1)
		chk_rd(OFS_IRQ_STAT, 32'h1 << EV_MAIN_LOSS);
		ahb(1'b1, OFS_IRQ_CLR, 32'h1 << EV_MAIN_LOSS);
		cycles(2);
		`CHK(irq, 1'b0)
		strobes(1'b0, 8'h09, 5);
		cycles(2);
		`CHK(irq, 1'b0)
		chk_rd(OFS_IRQ_STAT, 32'h1 << EV_MAIN_GAIN);
	endtask
	task automatic t_sync_async;
		int n;
		main_stuck <= 1'b1;
		ahb(1'b1, OFS_CTRL, 32'h1);
		cycles(8);
		`CHK({main_powered, main_pump_en}, 2'h2)
		`CHK(aux_powered, 1'b1)
		main_stuck <= 1'b0;
		for (n = 0; n < 30 && main_powered !== 1'b0; n++)
			@(posedge clk_sys);
		`CHK(main_powered, 1'b0)
		chk_rd(OFS_STATUS, 32'h22);
		main_stuck <= 1'b1;
		ahb(1'b1, OFS_CTRL, 32'h0);
		cycles(3);
		ahb(1'b1, OFS_CTRL, 32'h5);
		cycles(3);
		`CHK(main_powered, 1'b0)
		`CHK({aux_powered, aux_pump_en, aux_pump_highz}, 3'h6)
		main_stuck <= 1'b0;
	endtask
	task automatic t_highz_auto;
		ahb(1'b1, OFS_CTRL, 32'hC);
		cycles(3);
		`CHK({main_powered, main_pump_en, main_pump_highz}, 3'h7)
		`CHK({aux_powered, aux_pump_en, aux_pump_highz}, 3'h7)
		ahb(1'b1, OFS_CTRL, 32'h15);
		cycles(3);
		`CHK(main_powered, 1'b0)
		ahb(1'b1, OFS_MAIN_DIV, 32'h1234);
		cycles(3);
		`CHK({main_powered, main_pump_en, main_pump_highz}, 3'h6)
		`CHK(main_divider, 16'h1234)
	endtask
	task automatic t_enable_low;
		en_pin <= 1'b0;
		cycles(5);
		`CHK({main_powered, aux_powered}, 2'h0)
		chk_rd(OFS_STATUS, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		cycles(4);
		srst <= 1'b0;
		cycles(3);
		t_reset_regs();
		t_power_up();
		t_main_lock();
		t_aux_both();
		t_irq();
		t_sync_async();
		t_highz_auto();
		t_enable_low();
		tally_and_finish();
	end
endmodule
